/* hw/ihc_pkg.sv */
// ihc_pkg: constants and types for the host-side ide pio / multiword dma cycle engine
// Behaviour
// - pio cycle meets total, active, recovery minimums
// - host samples iordy after setup, then waits
// - after a wait, capture data after iordy
// - no wait handshake in pio modes 5, 6
// - byte register strobes use longer active width in modes 0-2
// - modes 3-6 keep recovery between strobes
// - address is two selects plus three lines
// - sixteen lines for words, eight for bytes
// - dma cycle meets total, active, negated minimums
// - dma write negated width longer in mode 0
// - host may drop acknowledge to suspend dma
package ihc_pkg;

  // ----------------------------------------------------------------
  // clock and synchroniser
  // ----------------------------------------------------------------
  localparam int CLK_NS = 100; // sys_clk period, 10 mhz
  localparam int SYNC_LAT = 3; // cycles from a pin's sampling edge to its agreed value
  localparam int PIO_MAX_MODE = 6; // fastest pio mode
  localparam int DMA_MAX_MODE = 4; // fastest multiword dma mode
  localparam int PIO_WAIT_MAX = 4; // last pio mode with the iordy wait

  // ----------------------------------------------------------------
  // pio timing in ns, indexed by mode 0..6
  // ----------------------------------------------------------------
  localparam int PIO_T0_NS [7] = '{600, 383, 240, 180, 120, 100, 80}; // total cycle
  localparam int PIO_T1_NS [7] = '{70, 50, 30, 30, 25, 15, 10}; // address to strobe
  localparam int PIO_T2_NS [7] = '{165, 125, 100, 80, 70, 65, 55}; // strobe active, word
  localparam int PIO_T2R_NS [7] = '{290, 290, 290, 80, 70, 65, 55}; // strobe active, byte reg
  localparam int PIO_T2I_NS [7] = '{0, 0, 0, 70, 25, 25, 20}; // recovery, none below mode 3
  localparam int PIO_T9_NS [7] = '{20, 15, 10, 10, 10, 10, 10}; // address hold
  localparam int PIO_TA_NS = 35; // iordy setup after strobe
  localparam int PIO_TB_NS = 1250; // longest iordy low pulse

  // ----------------------------------------------------------------
  // multiword dma timing in ns, indexed by mode 0..4
  // ----------------------------------------------------------------
  localparam int DMA_T0_NS [5] = '{480, 150, 120, 100, 80}; // total cycle
  localparam int DMA_TD_NS [5] = '{215, 80, 70, 65, 55}; // strobe active
  localparam int DMA_TKR_NS [5] = '{50, 50, 25, 25, 20}; // read strobe negated
  localparam int DMA_TKW_NS [5] = '{215, 50, 25, 25, 20}; // write strobe negated
  localparam int DMA_TLR_NS [5] = '{120, 40, 35, 35, 35}; // read strobe to dmarq
  localparam int DMA_TLW_NS [5] = '{40, 40, 35, 35, 35}; // write strobe to dmarq
  localparam int DMA_TM_NS [5] = '{50, 30, 25, 10, 5}; // selects valid to strobe

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {OP_PIO_RD, OP_PIO_WR, OP_DMA_RD, OP_DMA_WR} ihc_op_e;
  typedef enum logic [2:0] {ST_IDLE, ST_DREQ, ST_SETUP, ST_ACT, ST_WAIT, ST_REC} ihc_st_e;

  // least time to cycles: round up, never below one
  function automatic int ns_up(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  // longest time to cycles: round down, never below one
  function automatic int ns_dn(input int ns);
    int c;
    c = ns / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic logic op_is_rd(input ihc_op_e op);
    return (op == OP_PIO_RD) || (op == OP_DMA_RD);
  endfunction

  function automatic logic op_is_dma(input ihc_op_e op);
    return (op == OP_DMA_RD) || (op == OP_DMA_WR);
  endfunction

  // agreed iordy is looked at once it shows the pin as it stood one setup time after the strobe fell
  localparam logic [7:0] TA_CHK = 8'(ns_up(PIO_TA_NS) + SYNC_LAT + 1);
  // give up on a wait that outlasts the card's longest pulse plus sync delay
  localparam logic [7:0] WAIT_LIMIT = 8'(ns_dn(PIO_TB_NS) + SYNC_LAT + 1);

endpackage

/* hw/ihc_stream_if.sv */
// ihc_stream_if: valid/ready word channel between the cycle engine and its fifo
interface ihc_stream_if #(parameter int W = 16);
  logic valid; // word offered
  logic ready; // word can be taken
  logic [W-1:0] data; // the word
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

/* hw/ihc_fifo.sv */
// ihc_fifo: parameterised first-in first-out buffer for read words
module ihc_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 8
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  ihc_stream_if.snk push_s,
  output logic pop_valid,
  input wire logic pop_ready,
  output logic [W-1:0] pop_data
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem; // word store
    logic [AW-1:0] wp; // write pointer
    logic [AW-1:0] rp; // read pointer
    logic [AW:0] cnt; // words held
  } ihc_fifo_s;

  ihc_fifo_s r;
  ihc_fifo_s n;
  logic wr_en; // push taken this cycle
  logic rd_en; // pop taken this cycle

  // full and empty come straight from the count, so they never lie
  assign push_s.ready = (r.cnt != (AW+1)'(DEPTH));
  assign pop_valid = (r.cnt != '0);
  assign pop_data = r.mem[r.rp];
  assign wr_en = push_s.valid && push_s.ready;
  assign rd_en = pop_valid && pop_ready;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    n = r;
    if (wr_en) begin
      n.mem[r.wp] = push_s.data;
      n.wp = (r.wp == AW'(DEPTH - 1)) ? '0 : r.wp + AW'(1);
    end
    if (rd_en) begin
      n.rp = (r.rp == AW'(DEPTH - 1)) ? '0 : r.rp + AW'(1);
    end
    n.cnt = r.cnt + (AW+1)'(wr_en) - (AW+1)'(rd_en);
  end

  // register the whole state; reset clears the store along with the pointers and count
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

endmodule

/* hw/ihc_host.sv */
// ihc_host: host engine that runs pio and multiword dma cycles on the card pins
module ihc_host (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [1:0] cmd_op,
  input wire logic cmd_cs_high,
  input wire logic [2:0] cmd_addr,
  input wire logic cmd_byte,
  input wire logic [15:0] cmd_wdata,
  input wire logic [2:0] pio_mode,
  input wire logic [2:0] dma_mode,
  input wire logic dma_suspend,
  output logic cmd_done,
  output logic wait_timeout,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [15:0] rd_data,
  output logic [2:0] host_addr_low,
  output logic chip_select_low_n,
  output logic chip_select_high_n,
  output logic host_read_strobe_n,
  output logic host_write_strobe_n,
  output logic dma_acknowledge_line_n,
  output logic [15:0] host_data_bus_out,
  output logic host_data_bus_oe,
  input wire logic [15:0] host_data_bus_in,
  input wire logic iordy,
  input wire logic dmarq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    ihc_pkg::ihc_st_e st; // cycle phase
    ihc_pkg::ihc_op_e op; // cycle kind
    logic byte8; // 8-bit transfer
    logic wait_ok; // iordy still to be sampled
    logic [2:0] pmode; // pio mode of this cycle
    logic [7:0] set_min; // setup cycles
    logic [7:0] act_min; // strobe active cycles
    logic [7:0] rec_min; // recovery cycles
    logic [7:0] cyc_min; // total cycles from strobe
    logic [7:0] cnt; // cycles in phase
    logic [7:0] cyc; // cycles since strobe fell
    logic [2:0] addr; // register address lines
    logic cs0_n; // low select
    logic cs1_n; // high select
    logic rd_n; // read strobe
    logic wr_n; // write strobe
    logic ack_n; // dma acknowledge
    logic oe; // host owns data lines
    logic [15:0] wdata; // write word
    logic [15:0] rdata; // captured read word
    logic push; // read word to fifo
    logic done; // cycle finished
    logic tmo; // wait gave up
    logic [2:0] i_s; // iordy synchroniser
    logic i_f; // iordy, agreed
    logic [2:0] q_s; // dmarq synchroniser
    logic q_f; // dmarq, agreed
    logic [15:0] d_s1; // data synchroniser
    logic [15:0] d_s2;
    logic [15:0] d_s3;
    logic [15:0] d_f; // data, agreed per bit
  } ihc_host_s;

  ihc_host_s r;
  ihc_host_s n;
  ihc_stream_if #(.W(16)) push_s ();

  // ----------------------------------------------------------------
  // command decode and timing selection
  // ----------------------------------------------------------------
  int pm; // clamped pio mode
  int dm; // clamped dma mode
  int a; // active cycles
  int rc; // recovery cycles
  logic cmd_rd; // command reads
  logic cmd_dma; // command is dma
  logic cmd_fire; // command taken
  logic [7:0] t_set;
  logic [7:0] t_act;
  logic [7:0] t_rec;
  logic [7:0] t_cyc;

  assign cmd_rd = ihc_pkg::op_is_rd(ihc_pkg::ihc_op_e'(cmd_op));
  assign cmd_dma = ihc_pkg::op_is_dma(ihc_pkg::ihc_op_e'(cmd_op));
  // a read is only taken while the fifo has room, so a full fifo stalls the bus
  assign cmd_ready = (r.st == ihc_pkg::ST_IDLE) && (!cmd_rd || push_s.ready);
  assign cmd_fire = cmd_valid && cmd_ready;

  // per-mode minimums for the command now offered
  always_comb begin
    pm = (int'(pio_mode) > ihc_pkg::PIO_MAX_MODE) ? ihc_pkg::PIO_MAX_MODE : int'(pio_mode);
    dm = (int'(dma_mode) > ihc_pkg::DMA_MAX_MODE) ? ihc_pkg::DMA_MAX_MODE : int'(dma_mode);
    a = 0;
    rc = 0;
    if (cmd_dma) begin
      t_set = 8'(ihc_pkg::ns_up(ihc_pkg::DMA_TM_NS[dm]));
      a = ihc_pkg::ns_up(ihc_pkg::DMA_TD_NS[dm]);
      rc = ihc_pkg::ns_up(cmd_rd ? ihc_pkg::DMA_TKR_NS[dm] : ihc_pkg::DMA_TKW_NS[dm]);
      // leave time for a withdrawn dmarq to reach us before the next word
      if (ihc_pkg::ns_up(cmd_rd ? ihc_pkg::DMA_TLR_NS[dm] : ihc_pkg::DMA_TLW_NS[dm]) + ihc_pkg::SYNC_LAT + 1 > rc) begin
        rc = ihc_pkg::ns_up(cmd_rd ? ihc_pkg::DMA_TLR_NS[dm] : ihc_pkg::DMA_TLW_NS[dm]) + ihc_pkg::SYNC_LAT + 1;
      end
      t_cyc = 8'(ihc_pkg::ns_up(ihc_pkg::DMA_T0_NS[dm]));
    end else begin
      t_set = 8'(ihc_pkg::ns_up(ihc_pkg::PIO_T1_NS[pm]));
      a = ihc_pkg::ns_up(cmd_byte ? ihc_pkg::PIO_T2R_NS[pm] : ihc_pkg::PIO_T2_NS[pm]);
      rc = ihc_pkg::ns_up(ihc_pkg::PIO_T2I_NS[pm]);
      if (ihc_pkg::ns_up(ihc_pkg::PIO_T9_NS[pm]) > rc) begin
        rc = ihc_pkg::ns_up(ihc_pkg::PIO_T9_NS[pm]);
      end
      // strobe must still be low when iordy is looked at
      if (pm <= ihc_pkg::PIO_WAIT_MAX && a < int'(ihc_pkg::TA_CHK) + 1) begin
        a = int'(ihc_pkg::TA_CHK) + 1;
      end
      t_cyc = 8'(ihc_pkg::ns_up(ihc_pkg::PIO_T0_NS[pm]));
    end
    // reads stay active until the word captured is the pin as it stood at the unstretched strobe end
    if (cmd_rd) begin
      a = a + ihc_pkg::SYNC_LAT + 1;
    end
    t_act = 8'(a);
    t_rec = 8'(rc);
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    n = r;
    n.push = 1'b0;
    n.done = 1'b0;
    n.tmo = 1'b0;
    // pins: three flops, a change counts once stages two and three agree
    n.i_s = {r.i_s[1:0], iordy};
    n.i_f = (r.i_s[1] == r.i_s[2]) ? r.i_s[2] : r.i_f;
    n.q_s = {r.q_s[1:0], dmarq};
    n.q_f = (r.q_s[1] == r.q_s[2]) ? r.q_s[2] : r.q_f;
    n.d_s1 = host_data_bus_in;
    n.d_s2 = r.d_s1;
    n.d_s3 = r.d_s2;
    n.d_f = (~(r.d_s2 ^ r.d_s3) & r.d_s3) | ((r.d_s2 ^ r.d_s3) & r.d_f);
    // counters saturate so a stuck phase cannot wrap
    n.cnt = (r.cnt == 8'hff) ? r.cnt : r.cnt + 8'h01;
    n.cyc = (r.cyc == 8'hff) ? r.cyc : r.cyc + 8'h01;
    unique case (r.st)
      // wait for a command
      ihc_pkg::ST_IDLE: begin
        if (cmd_fire) begin
          n.op = ihc_pkg::ihc_op_e'(cmd_op);
          n.byte8 = cmd_byte;
          n.wdata = cmd_byte ? {8'h00, cmd_wdata[7:0]} : cmd_wdata;
          n.pmode = 3'(pm);
          n.wait_ok = !cmd_dma && (pm <= ihc_pkg::PIO_WAIT_MAX);
          n.set_min = t_set;
          n.act_min = t_act;
          n.rec_min = t_rec;
          n.cyc_min = t_cyc;
          n.cnt = 8'h00;
          if (cmd_dma) begin
            n.ack_n = 1'b0;
            n.cs0_n = 1'b1;
            n.cs1_n = 1'b1;
            n.st = ihc_pkg::ST_DREQ;
          end else begin
            n.ack_n = 1'b1;
            n.cs0_n = cmd_cs_high;
            n.cs1_n = !cmd_cs_high;
            n.addr = cmd_addr;
            n.oe = !cmd_rd;
            n.st = ihc_pkg::ST_SETUP;
          end
        end else if (!(cmd_valid && cmd_dma) || dma_suspend) begin
          n.ack_n = 1'b1;
        end
      end
      // dma word waits for the card's request and our own acknowledge
      ihc_pkg::ST_DREQ: begin
        n.ack_n = dma_suspend;
        if (r.q_f && !r.ack_n && !dma_suspend) begin
          n.oe = !ihc_pkg::op_is_rd(r.op);
          n.cnt = 8'h00;
          n.st = ihc_pkg::ST_SETUP;
        end
      end
      // address and selects settle before the strobe
      ihc_pkg::ST_SETUP: begin
        if (r.cnt + 8'h01 >= r.set_min) begin
          n.rd_n = !ihc_pkg::op_is_rd(r.op);
          n.wr_n = ihc_pkg::op_is_rd(r.op);
          n.cyc = 8'h00;
          n.st = ihc_pkg::ST_ACT;
        end
      end
      // strobe active
      ihc_pkg::ST_ACT: begin
        if (r.wait_ok && (r.cyc + 8'h01 == ihc_pkg::TA_CHK) && !r.i_f) begin
          n.cnt = 8'h00;
          n.st = ihc_pkg::ST_WAIT;
        end else if (r.cyc + 8'h01 >= r.act_min) begin
          n.rd_n = 1'b1;
          n.wr_n = 1'b1;
          n.cnt = 8'h00;
          n.st = ihc_pkg::ST_REC;
          if (ihc_pkg::op_is_rd(r.op)) begin
            n.rdata = r.byte8 ? {8'h00, r.d_f[7:0]} : r.d_f;
            n.push = 1'b1;
          end
        end
      end
      // card holds iordy low; strobe stays active
      ihc_pkg::ST_WAIT: begin
        if (r.i_f || r.cnt >= ihc_pkg::WAIT_LIMIT) begin
          n.tmo = !r.i_f;
          n.wait_ok = 1'b0;
          // data is only trusted once it has had time to pass the synchroniser
          if (r.cyc + 8'(ihc_pkg::SYNC_LAT + 1) > r.act_min) begin
            n.act_min = r.cyc + 8'(ihc_pkg::SYNC_LAT + 1);
          end
          n.st = ihc_pkg::ST_ACT;
        end
      end
      // both strobes off until recovery and total cycle are met
      ihc_pkg::ST_REC: begin
        if (r.cnt + 8'h01 >= r.rec_min && r.cyc + 8'h01 >= r.cyc_min) begin
          n.oe = 1'b0;
          n.done = 1'b1;
          n.st = ihc_pkg::ST_IDLE;
        end
      end
    endcase
  end

  // register the whole state; idle pins come out of reset negated
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      r <= '0;
      r.cs0_n <= 1'b1;
      r.cs1_n <= 1'b1;
      r.rd_n <= 1'b1;
      r.wr_n <= 1'b1;
      r.ack_n <= 1'b1;
      // iordy idles high; starting low would fake a wait on an early read
      r.i_s <= 3'h7;
      r.i_f <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------
  // outputs and read buffer
  // ----------------------------------------------------------------
  assign host_addr_low = r.addr;
  assign chip_select_low_n = r.cs0_n;
  assign chip_select_high_n = r.cs1_n;
  assign host_read_strobe_n = r.rd_n;
  assign host_write_strobe_n = r.wr_n;
  assign dma_acknowledge_line_n = r.ack_n;
  assign host_data_bus_out = r.wdata;
  assign host_data_bus_oe = r.oe;
  assign cmd_done = r.done;
  assign wait_timeout = r.tmo;
  assign push_s.valid = r.push;
  assign push_s.data = r.rdata;

  ihc_fifo #(.W(16), .DEPTH(8)) u_fifo (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .push_s(push_s),
    .pop_valid(rd_valid),
    .pop_ready(rd_ready),
    .pop_data(rd_data)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence s_wait_seen;
    r.st == ihc_pkg::ST_WAIT && r.i_f;
  endsequence
  sequence s_strobes_off;
    host_read_strobe_n && host_write_strobe_n;
  endsequence

  a_cycle_total:
  assert property (r.st == ihc_pkg::ST_REC && n.st == ihc_pkg::ST_IDLE |-> r.cyc + 8'h01 >= r.cyc_min)
    else $error("cycle ended before its total minimum");
  a_recovery_min:
  assert property (r.st == ihc_pkg::ST_REC && n.st == ihc_pkg::ST_IDLE |-> r.cnt + 8'h01 >= r.rec_min)
    else $error("recovery shorter than minimum");
  a_wait_hold:
  assert property (r.st == ihc_pkg::ST_WAIT && !r.i_f |=> !(host_read_strobe_n && host_write_strobe_n))
    else $error("strobe released while iordy low");
  a_wait_release:
  assert property (s_wait_seen |-> ##[2:5] s_strobes_off)
    else $error("strobe not released after iordy returned");
  a_no_fast_wait:
  assert property (r.st == ihc_pkg::ST_WAIT |-> int'(r.pmode) <= ihc_pkg::PIO_WAIT_MAX)
    else $error("wait taken in a mode without iordy");
  a_byte_width:
  assert property ($rose(host_read_strobe_n) && r.byte8 && !ihc_pkg::op_is_dma(r.op) && r.pmode <= 3'h2
    |-> $past(r.cyc) + 8'h01 >= 8'(ihc_pkg::ns_up(ihc_pkg::PIO_T2R_NS[0])))
    else $error("byte register strobe too short");
  a_one_select:
  assert property (!(host_read_strobe_n && host_write_strobe_n) && dma_acknowledge_line_n
    |-> chip_select_low_n != chip_select_high_n)
    else $error("pio cycle without exactly one select");
  a_byte_lanes:
  assert property (push_s.valid && r.byte8 |-> push_s.data[15:8] == 8'h00)
    else $error("byte read carries upper lanes");
  a_dma_ack:
  assert property (!(host_read_strobe_n && host_write_strobe_n) && ihc_pkg::op_is_dma(r.op)
    |-> !dma_acknowledge_line_n && chip_select_low_n && chip_select_high_n)
    else $error("dma strobe without acknowledge");
  a_dmarq_gate:
  assert property ($fell(host_read_strobe_n && host_write_strobe_n) && ihc_pkg::op_is_dma(r.op)
    |-> $past(r.q_f, 2))
    else $error("dma word started without request");
  a_bus_owner:
  assert property (host_data_bus_oe |-> host_read_strobe_n)
    else $error("host drives bus during a read");

endmodule

/* bench/ihc_card_model.sv */
// ihc_card_model: behavioural card that answers pio and multiword dma cycles
module ihc_card_model (
  input wire logic sys_clk,
  input wire logic [2:0] host_addr_low,
  input wire logic chip_select_low_n,
  input wire logic chip_select_high_n,
  input wire logic host_read_strobe_n,
  input wire logic host_write_strobe_n,
  input wire logic dma_acknowledge_line_n,
  input wire logic [15:0] host_data_bus_out,
  input wire logic host_data_bus_oe,
  input wire logic [7:0] wait_cyc, // bench-commanded wait length, cycles
  input wire logic dreq_en, // bench-commanded request level
  output logic [15:0] bus_level,
  output logic iordy,
  output logic dmarq
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------
  logic [15:0] mem [16]; // register file
  logic [15:0] last = 16'h0000; // last bus level, inverted when floating
  logic [15:0] dma_cnt = 16'h0000; // dma read words sent
  logic [15:0] dma_last = 16'h0000; // last dma word received
  logic [7:0] wcnt = 8'h00; // cycles since strobe fell
  logic rd_q = 1'b1;
  logic wr_q = 1'b1;
  logic [3:0] idx;
  logic pio;
  logic strobe;
  logic card_oe;
  logic [15:0] card_d;
  assign pio = dma_acknowledge_line_n; // ack high: register cycle
  assign strobe = !host_read_strobe_n || !host_write_strobe_n;
  assign idx = {!chip_select_high_n, host_addr_low};
  // low from strobe fall, so always ahead of the host look
  assign iordy = !(pio && strobe && wcnt < wait_cyc);
  assign card_oe = !host_read_strobe_n && (!pio || (chip_select_low_n != chip_select_high_n));
  // junk while waiting, so a host that samples early is caught
  assign card_d = !pio ? 16'ha500 + dma_cnt : iordy ? mem[idx] : ~mem[idx];
  // floating bus toggles rather than holding the last value
  assign bus_level = host_data_bus_oe ? host_data_bus_out : card_oe ? card_d : ~last;
  assign dmarq = dreq_en;
  // 16-bit flag for the data register only; this host takes width from its command
  logic wide_n;
  assign wide_n = !(pio && !chip_select_low_n && host_addr_low == 3'h0);
  // capture writes at strobe rise, count dma reads
  always @(posedge sys_clk) begin
    last <= bus_level;
    wcnt <= strobe ? wcnt + 8'h01 : 8'h00;
    rd_q <= host_read_strobe_n;
    wr_q <= host_write_strobe_n;
    if (host_write_strobe_n && !wr_q) begin
      if (pio) mem[idx] <= bus_level;
      else dma_last <= bus_level;
    end
    if (host_read_strobe_n && !rd_q && !pio) dma_cnt <= dma_cnt + 16'h0001;
  end
endmodule

/* bench/ide_pio_mwdma_bus_cycles_tb_top.sv */
// ide_pio_mwdma_bus_cycles_tb_top: self-checking bench for the host cycle engine
module ide_pio_mwdma_bus_cycles_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] op;
    logic csh;
    logic [2:0] a;
    logic byt;
    logic [15:0] wd;
    logic [2:0] md;
    logic [15:0] ex;
  } ihc_row_s;
  // writes first, then read-backs in pio modes 0, 2, 4, 5 and 6
  ihc_row_s rows [9] = '{'{2'h1, 1'b0, 3'h1, 1'b0, 16'h1234, 3'h0, 16'h0000},
    '{2'h1, 1'b1, 3'h6, 1'b1, 16'h12ab, 3'h3, 16'h0000}, '{2'h1, 1'b0, 3'h7, 1'b0, 16'hbeef, 3'h6, 16'h0000},
    '{2'h1, 1'b1, 3'h0, 1'b0, 16'h5a5a, 3'h1, 16'h0000}, '{2'h0, 1'b0, 3'h1, 1'b0, 16'h0000, 3'h5, 16'h1234},
    '{2'h0, 1'b1, 3'h6, 1'b0, 16'h0000, 3'h4, 16'h00ab}, '{2'h0, 1'b0, 3'h7, 1'b1, 16'h0000, 3'h2, 16'h00ef},
    '{2'h0, 1'b1, 3'h0, 1'b0, 16'h0000, 3'h0, 16'h5a5a}, '{2'h0, 1'b0, 3'h7, 1'b0, 16'h0000, 3'h6, 16'hbeef}};
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_cs_high = 1'b0;
  logic cmd_byte = 1'b0;
  logic dma_suspend = 1'b0;
  logic rd_ready = 1'b0;
  logic dreq_en = 1'b0;
  logic [1:0] cmd_op = 2'h0;
  logic [2:0] cmd_addr = 3'h0;
  logic [2:0] pio_mode = 3'h0;
  logic [2:0] dma_mode = 3'h0;
  logic [15:0] cmd_wdata = 16'h0000;
  logic [7:0] wait_cyc = 8'h00;
  logic cmd_ready, cmd_done, wait_timeout, rd_valid, iordy, dmarq, host_data_bus_oe;
  logic chip_select_low_n, chip_select_high_n, host_read_strobe_n, host_write_strobe_n, dma_acknowledge_line_n;
  logic [2:0] host_addr_low;
  logic [15:0] rd_data, host_data_bus_out, bus_level;
  int err_total = 0;
  int checks = 0;
  int cyc = 0;
  int low_cnt = 0; // cycles with a strobe low
  int to_cnt = 0; // timeout pulses seen
  int neg_w = -1; // write strobe high cycles since it last rose, -1 before the first
  int min_neg = 99;
  ihc_host i_dut (.sys_clk, .sys_rst, .cmd_valid, .cmd_ready, .cmd_op, .cmd_cs_high, .cmd_addr, .cmd_byte,
    .cmd_wdata, .pio_mode, .dma_mode, .dma_suspend, .cmd_done, .wait_timeout, .rd_valid, .rd_ready, .rd_data,
    .host_addr_low, .chip_select_low_n, .chip_select_high_n, .host_read_strobe_n, .host_write_strobe_n,
    .dma_acknowledge_line_n, .host_data_bus_out, .host_data_bus_oe, .host_data_bus_in(bus_level), .iordy, .dmarq);
  ihc_card_model i_card (.sys_clk, .host_addr_low, .chip_select_low_n, .chip_select_high_n, .host_read_strobe_n,
    .host_write_strobe_n, .dma_acknowledge_line_n, .host_data_bus_out, .host_data_bus_oe, .wait_cyc, .dreq_en,
    .bus_level, .iordy, .dmarq);
  // 100 ns period
  initial begin
    forever #50 sys_clk = ~sys_clk;
  end
  // pin monitor and hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (!host_read_strobe_n || !host_write_strobe_n) low_cnt++;
    if (wait_timeout === 1'b1) to_cnt++;
    // only strobe-to-strobe gaps count, including any wait for a request between two words
    if (!host_write_strobe_n) begin
      if (neg_w > 0 && neg_w < min_neg) min_neg = neg_w;
      neg_w = 0;
    end else if (neg_w >= 0) neg_w++;
    if (cyc == 20000) begin
      err_total++;
      stop_test();
    end
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // hold the request until the edge that takes it
  task offer(input logic [1:0] op, input logic csh, input logic [2:0] a, input logic byt,
    input logic [15:0] wd, input logic [2:0] md);
    @(negedge sys_clk);
    cmd_op = op;
    cmd_cs_high = csh;
    cmd_addr = a;
    cmd_byte = byt;
    cmd_wdata = wd;
    pio_mode = md;
    dma_mode = md;
    cmd_valid = 1'b1;
    while (cmd_ready !== 1'b1) @(negedge sys_clk);
    @(negedge sys_clk);
    cmd_valid = 1'b0;
  endtask
  task cmd(input logic [1:0] op, input logic csh, input logic [2:0] a, input logic byt,
    input logic [15:0] wd, input logic [2:0] md);
    offer(op, csh, a, byt, wd, md);
    while (cmd_done !== 1'b1) @(negedge sys_clk);
  endtask
  // take one word from the read fifo
  task pop(input logic [15:0] ex);
    @(negedge sys_clk);
    while (rd_valid !== 1'b1) @(negedge sys_clk);
    chk(rd_data, ex);
    rd_ready = 1'b1;
    @(negedge sys_clk);
    rd_ready = 1'b0;
  endtask
  task stop_test();
    if (err_total == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge sys_clk);
    chk({host_read_strobe_n, host_write_strobe_n, chip_select_low_n, chip_select_high_n,
      dma_acknowledge_line_n, host_data_bus_oe, cmd_ready, rd_valid}, 8'hfa);
    @(negedge sys_clk);
    sys_rst = 1'b0;
    repeat (8) @(negedge sys_clk);
    foreach (rows[i]) begin
      cmd(rows[i].op, rows[i].csh, rows[i].a, rows[i].byt, rows[i].wd, rows[i].md);
      if (rows[i].op == 2'h0) pop(rows[i].ex);
    end
    chk(i_card.mem[4'he], 16'h00ab);
    chk(i_card.wide_n, 1'b1);
    // card wait on a mode 0 read: strobe held, data from iordy rise
    wait_cyc = 8'h08;
    low_cnt = 0;
    cmd(2'h0, 1'b0, 3'h1, 1'b0, 16'h0000, 3'h0);
    chk(32'(low_cnt >= 11), 32'h1);
    pop(16'h1234);
    // mode 5 does not wait even when iordy is low
    low_cnt = 0;
    cmd(2'h1, 1'b0, 3'h2, 1'b0, 16'h0f0f, 3'h5);
    chk(32'(low_cnt < 8), 32'h1);
    // a wait beyond the longest pulse is cut short
    wait_cyc = 8'h1e;
    low_cnt = 0;
    to_cnt = 0;
    cmd(2'h1, 1'b0, 3'h3, 1'b0, 16'h00ff, 3'h1);
    chk(to_cnt, 32'h1);
    chk(32'(low_cnt < 30), 32'h1);
    wait_cyc = 8'h00;
    // dma reads fill the fifo until reads are refused
    dreq_en = 1'b1;
    repeat (8) cmd(2'h2, 1'b0, 3'h0, 1'b0, 16'h0000, 3'h4);
    chk(cmd_ready, 1'b0);
    // withdraw the request early so the synchroniser has settled before the write
    dreq_en = 1'b0;
    for (int k = 0; k < 8; k++) pop(16'ha500 + 16'(k));
    chk(rd_valid, 1'b0);
    // dma write held by the card, then by the host, then resumed
    min_neg = 99;
    low_cnt = 0;
    offer(2'h3, 1'b0, 3'h0, 1'b0, 16'hc3c3, 3'h0);
    repeat (20) @(negedge sys_clk);
    chk(low_cnt, 32'h0);
    dma_suspend = 1'b1;
    dreq_en = 1'b1;
    repeat (20) @(negedge sys_clk);
    chk({low_cnt[7:0], dma_acknowledge_line_n}, 9'h001);
    dma_suspend = 1'b0;
    while (cmd_done !== 1'b1) @(negedge sys_clk);
    chk(i_card.dma_last, 16'hc3c3);
    cmd(2'h3, 1'b0, 3'h0, 1'b0, 16'h3c3c, 3'h0);
    chk(i_card.dma_last, 16'h3c3c);
    chk(32'(min_neg >= 3), 32'h1);
    chk(32'(low_cnt >= 6), 32'h1);
    stop_test();
  end
endmodule
